/* logic/bank_parity_map.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_regs.svh"

module bank_parity_map (
    input wire logic [7:0] acc_in,
    input wire logic bank_select_high_in,
    input wire logic bank_select_low_in,
    output logic parity_out,
    output logic [4:0] bank_base_out
);

    // odd count of ones gives a set parity bit, combinational from the accumulator with no clock
    assign parity_out = ^acc_in;

    // bank n starts at n times eight bytes
    assign bank_base_out = 5'({bank_select_high_in, bank_select_low_in} * `BANK_BYTES);

endmodule
`default_nettype wire

/* logic/cpu_core_pkg.sv */
`default_nettype none
package cpu_core_pkg;

    // operation codes carried in the command register
    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV, OP_DA,
        OP_RRC, OP_RLC, OP_CLRC, OP_SETBC, OP_CPLC, OP_ANLC, OP_ANLCN,
        OP_ORLC, OP_ORLCN, OP_MOVC, OP_CJNE, OP_JMP, OP_CALL,
        OP_ANL, OP_ORL, OP_XRL, OP_MOVA
    } alu_op_t;

    // status word layout, bit 7 first
    typedef struct packed {
        logic carry_out_flag;
        logic half_carry_flag;
        logic user_flag_zero;
        logic bank_select_high;
        logic bank_select_low;
        logic signed_range_flag;
        logic user_flag_one;
        logic parity_flag;
    } psw_t;

    // latched instruction command
    typedef struct packed {
        logic [7:0] operand;
        logic [5:0] spare_hi;
        logic [1:0] bytes;
        logic [2:0] spare_lo;
        alu_op_t op;
    } cmd_t;

    // datapath result of one instruction
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] b;
        logic cy;
        logic ac;
        logic ov;
    } exec_t;

endpackage
`default_nettype wire

/* logic/cpu_core_regs.svh */
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_STAT 8'h04
`define OFS_PSW 8'hd0
`define OFS_ACC 8'he0
`define OFS_B 8'hf0

// ---------------------------------------------------------------
// status word bit positions
// ---------------------------------------------------------------
`define PSW_CARRY_BIT 7
`define PSW_HALF_BIT 6
`define PSW_USER0_BIT 5
`define PSW_BANK_HI_BIT 4
`define PSW_BANK_LO_BIT 3
`define PSW_SIGNED_BIT 2
`define PSW_USER1_BIT 1
`define PSW_PARITY_BIT 0
`define PSW_WR_MASK 8'hfe

// ---------------------------------------------------------------
// command and status field positions
// ---------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_BYTES_LSB 8
`define CMD_OPND_LSB 16
`define STAT_BUSY_BIT 0
`define STAT_PHASE_LSB 4
`define STAT_MCYC_LSB 8

// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
`define RST_PSW 8'h00
`define RST_ACC 8'h00
`define RST_B 8'h00
`define CLKS_PER_MCYCLE 4
`define BANK_BYTES 8

`endif

/* logic/cpu_flags_and_cycle_timing.sv */
// Function
// - machine cycle is four core clocks
// - at most one byte fetch per machine cycle
// - machine cycles equal byte count normally
// - jumps and calls take one extra cycle
// - standard instruction effects on flags kept
// - per-instruction carry, overflow, half-carry updates
// - carry from alu, also bit accumulator
// - half carry is carry out of bit 3
// - user flags only software written
// - bank select maps r0-r7 to four banks
// - overflow is carry6 xor carry7
// - parity follows accumulator ones count
// - 8-bit accumulator readable and writable
// - second operand register for multiply, divide
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_regs.svh"

module cpu_flags_and_cycle_timing #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic busy_out,
    output logic fetch_strobe_out,
    output logic [4:0] bank_base_out,
    output cpu_core_pkg::psw_t psw_out,
    output logic [7:0] acc_out,
    output logic [7:0] b_out
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    cpu_core_pkg::psw_t psw_q;
    cpu_core_pkg::cmd_t cmd_q;
    cpu_core_pkg::exec_t res;
    logic [7:0] acc_q;
    logic [7:0] b_q;
    logic parity;
    logic busy;
    logic last;
    logic [1:0] phase;
    logic [2:0] mcyc;
    logic [2:0] total;
    logic [2:0] fetches;
    logic access;
    logic wr_ok;
    logic mapped;
    logic hit_cmd;
    logic hit_stat;
    logic hit_psw;
    logic hit_acc;
    logic hit_b;
    logic start;
    cpu_core_pkg::cmd_t new_cmd;

    // ---------------------------------------------------------------
    // datapath helpers
    // ---------------------------------------------------------------

    // add with carry in; carries taken at bit 3, bit 6 and bit 7
    function automatic cpu_core_pkg::exec_t add8(input logic [7:0] a,
                                                 input logic [7:0] d,
                                                 input logic ci);
        cpu_core_pkg::exec_t r;
        logic [8:0] s9;
        logic [4:0] s4;
        logic [7:0] s7;
        r = '0;
        s9 = {1'b0, a} + {1'b0, d} + {8'h00, ci};
        s4 = {1'b0, a[3:0]} + {1'b0, d[3:0]} + {4'h0, ci};
        s7 = {1'b0, a[6:0]} + {1'b0, d[6:0]} + {7'h00, ci};
        r.acc = s9[7:0];
        r.cy = s9[8];
        r.ac = s4[4];
        r.ov = s7[7] ^ s9[8];
        return r;
    endfunction

    // subtract with borrow; borrows reported in the same carry slots
    function automatic cpu_core_pkg::exec_t sub8(input logic [7:0] a,
                                                 input logic [7:0] d,
                                                 input logic bi);
        cpu_core_pkg::exec_t r;
        logic [8:0] s9;
        logic [4:0] s4;
        logic [7:0] s7;
        r = '0;
        s9 = {1'b0, a} - {1'b0, d} - {8'h00, bi};
        s4 = {1'b0, a[3:0]} - {1'b0, d[3:0]} - {4'h0, bi};
        s7 = {1'b0, a[6:0]} - {1'b0, d[6:0]} - {7'h00, bi};
        r.acc = s9[7:0];
        r.cy = s9[8];
        r.ac = s4[4];
        r.ov = s7[7] ^ s9[8];
        return r;
    endfunction

    // decimal adjust; carry may be set, never cleared
    function automatic cpu_core_pkg::exec_t dadj(input logic [7:0] a,
                                                 input logic c,
                                                 input logic h);
        cpu_core_pkg::exec_t r;
        logic [8:0] t;
        logic cf;
        r = '0;
        t = {1'b0, a};
        if (a[3:0] > 4'h9 || h) begin
            t = t + 9'h006;
        end
        // carry kept apart so an incoming carry is never lost to wrap
        cf = c | t[8];
        if (t[7:4] > 4'h9 || cf) begin
            t = {1'b0, t[7:0]} + 9'h060;
        end
        r.acc = t[7:0];
        r.cy = cf | t[8];
        return r;
    endfunction

    // ---------------------------------------------------------------
    // instruction execution
    // ---------------------------------------------------------------

    // flag effects per operation; untouched flags keep their value
    always_comb begin
        logic [15:0] prod;
        logic bitv;
        cpu_core_pkg::exec_t da;
        prod = acc_q * b_q;
        da = dadj(acc_q, psw_q.carry_out_flag, psw_q.half_carry_flag);
        bitv = cmd_q.operand[0];
        res.acc = acc_q;
        res.b = b_q;
        res.cy = psw_q.carry_out_flag;
        res.ac = psw_q.half_carry_flag;
        res.ov = psw_q.signed_range_flag;
        unique case (cmd_q.op)
            cpu_core_pkg::OP_NOP: begin
            end
            cpu_core_pkg::OP_ADD: begin
                res = add8(acc_q, cmd_q.operand, 1'b0);
                res.b = b_q;
            end
            cpu_core_pkg::OP_ADDC: begin
                res = add8(acc_q, cmd_q.operand, psw_q.carry_out_flag);
                res.b = b_q;
            end
            cpu_core_pkg::OP_SUBB: begin
                res = sub8(acc_q, cmd_q.operand, psw_q.carry_out_flag);
                res.b = b_q;
            end
            cpu_core_pkg::OP_MUL: begin
                res.acc = prod[7:0];
                res.b = prod[15:8];
                res.cy = 1'b0;
                res.ov = (prod[15:8] != 8'h00);
            end
            cpu_core_pkg::OP_DIV: begin
                res.cy = 1'b0;
                res.ov = (b_q == 8'h00);
                if (b_q != 8'h00) begin
                    res.acc = acc_q / b_q;
                    res.b = acc_q % b_q;
                end
            end
            cpu_core_pkg::OP_DA: begin
                res.acc = da.acc;
                res.cy = da.cy;
            end
            cpu_core_pkg::OP_RRC: begin
                {res.acc, res.cy} = {psw_q.carry_out_flag, acc_q};
            end
            cpu_core_pkg::OP_RLC: begin
                {res.cy, res.acc} = {acc_q, psw_q.carry_out_flag};
            end
            cpu_core_pkg::OP_CLRC: res.cy = 1'b0;
            cpu_core_pkg::OP_SETBC: res.cy = 1'b1;
            cpu_core_pkg::OP_CPLC: res.cy = ~psw_q.carry_out_flag;
            cpu_core_pkg::OP_ANLC: res.cy = psw_q.carry_out_flag & bitv;
            cpu_core_pkg::OP_ANLCN: res.cy = psw_q.carry_out_flag & ~bitv;
            cpu_core_pkg::OP_ORLC: res.cy = psw_q.carry_out_flag | bitv;
            cpu_core_pkg::OP_ORLCN: res.cy = psw_q.carry_out_flag | ~bitv;
            cpu_core_pkg::OP_MOVC: res.cy = bitv;
            cpu_core_pkg::OP_CJNE: res.cy = (acc_q < cmd_q.operand);
            cpu_core_pkg::OP_JMP, cpu_core_pkg::OP_CALL: begin
            end
            cpu_core_pkg::OP_ANL: res.acc = acc_q & cmd_q.operand;
            cpu_core_pkg::OP_ORL: res.acc = acc_q | cmd_q.operand;
            cpu_core_pkg::OP_XRL: res.acc = acc_q ^ cmd_q.operand;
            cpu_core_pkg::OP_MOVA: res.acc = cmd_q.operand;
            default: begin
            end
        endcase
    end

    // ---------------------------------------------------------------
    // cycle budget of the latched instruction
    // ---------------------------------------------------------------

    // a zero byte count is taken as one byte
    function automatic logic [2:0] byte_count(input logic [1:0] b);
        return (b == 2'h0) ? 3'h1 : {1'b0, b};
    endfunction

    // fetch budget comes from the command being started, not the old one
    assign fetches = byte_count(new_cmd.bytes);

    // control transfers need one cycle to form the new address
    always_comb begin
        logic [2:0] nb;
        nb = byte_count(new_cmd.bytes);
        unique case (new_cmd.op)
            cpu_core_pkg::OP_JMP, cpu_core_pkg::OP_CALL,
            cpu_core_pkg::OP_CJNE: total = nb + 3'h1;
            default: total = nb;
        endcase
    end

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    assign access = psel_in && penable_in;
    assign hit_cmd = (paddr_in == ADDR_W'(`OFS_CMD));
    assign hit_stat = (paddr_in == ADDR_W'(`OFS_STAT));
    assign hit_psw = (paddr_in == ADDR_W'(`OFS_PSW));
    assign hit_acc = (paddr_in == ADDR_W'(`OFS_ACC));
    assign hit_b = (paddr_in == ADDR_W'(`OFS_B));
    assign mapped = hit_cmd | hit_stat | hit_psw | hit_acc | hit_b;

    // writes wait while an instruction runs, so software and the
    // datapath never update the same register in one cycle
    assign pready_out = !(psel_in && pwrite_in && busy);
    assign wr_ok = access && pwrite_in && !busy && mapped;
    assign pslverr_out = access && pready_out && !mapped;
    assign new_cmd = cpu_core_pkg::cmd_t'(pwdata_in[23:0]);
    assign start = wr_ok && hit_cmd;

    // read mux; unused bits read as zero
    always_comb begin
        prdata_out = 32'h0000_0000;
        if (hit_cmd) begin
            prdata_out[23:0] = cmd_q;
        end else if (hit_stat) begin
            prdata_out[`STAT_BUSY_BIT] = busy;
            prdata_out[`STAT_PHASE_LSB +: 2] = phase;
            prdata_out[`STAT_MCYC_LSB +: 3] = mcyc;
        end else if (hit_psw) begin
            prdata_out[7:0] = psw_out;
        end else if (hit_acc) begin
            prdata_out[7:0] = acc_q;
        end else if (hit_b) begin
            prdata_out[7:0] = b_q;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------

    // command latch, taken only when idle
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            cmd_q <= '0;
        end else if (start) begin
            cmd_q <= new_cmd;
        end
    end

    // accumulator: software write or instruction result
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            acc_q <= `RST_ACC;
        end else if (wr_ok && hit_acc) begin
            acc_q <= pwdata_in[7:0];
        end else if (last) begin
            acc_q <= res.acc;
        end
    end

    // second operand register
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            b_q <= `RST_B;
        end else if (wr_ok && hit_b) begin
            b_q <= pwdata_in[7:0];
        end else if (last) begin
            b_q <= res.b;
        end
    end

    // status word; parity is not stored, it is derived from the
    // accumulator so it can never go stale
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            psw_q <= `RST_PSW;
        end else if (wr_ok && hit_psw) begin
            psw_q <= pwdata_in[7:0] & `PSW_WR_MASK;
        end else if (last) begin
            psw_q.carry_out_flag <= res.cy;
            psw_q.half_carry_flag <= res.ac;
            psw_q.signed_range_flag <= res.ov;
        end
    end

    // ---------------------------------------------------------------
    // sub-blocks
    // ---------------------------------------------------------------
    mcycle_sequencer #(
        .CLKS_PER_MC(`CLKS_PER_MCYCLE)
    ) u_seq (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .start_in(start),
        .total_in(total),
        .fetches_in(fetches),
        .busy_out(busy),
        .fetch_out(fetch_strobe_out),
        .last_out(last),
        .phase_out(phase),
        .mcycle_out(mcyc)
    );

    bank_parity_map u_map (
        .acc_in(acc_q),
        .bank_select_high_in(psw_q.bank_select_high),
        .bank_select_low_in(psw_q.bank_select_low),
        .parity_out(parity),
        .bank_base_out(bank_base_out)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_comb begin
        psw_out = psw_q;
        psw_out.parity_flag = parity;
    end

    assign busy_out = busy;
    assign acc_out = acc_q;
    assign b_out = b_q;

endmodule
`default_nettype wire

/* logic/mcycle_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_regs.svh"

module mcycle_sequencer #(
    parameter int CLKS_PER_MC = `CLKS_PER_MCYCLE
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic [2:0] total_in,
    input wire logic [2:0] fetches_in,
    output logic busy_out,
    output logic fetch_out,
    output logic last_out,
    output logic [1:0] phase_out,
    output logic [2:0] mcycle_out
);

    logic busy_q;
    logic [1:0] phase_q;
    logic [2:0] mcyc_q;
    logic [2:0] total_q;
    logic [2:0] fetches_q;
    logic end_of_mc;

    // ---------------------------------------------------------------
    // clock phase inside a machine cycle
    // ---------------------------------------------------------------
    assign end_of_mc = (phase_q == 2'(CLKS_PER_MC - 1));

    // four clocks make one machine cycle
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || !busy_q) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= end_of_mc ? 2'h0 : phase_q + 2'h1;
        end
    end

    // machine cycle index, counted only on cycle boundaries
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || !busy_q) begin
            mcyc_q <= 3'h0;
        end else if (end_of_mc) begin
            mcyc_q <= mcyc_q + 3'h1;
        end
    end

    // length of the running instruction, caught at start
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            total_q <= 3'h1;
            fetches_q <= 3'h1;
        end else if (start_in && !busy_q) begin
            total_q <= total_in;
            fetches_q <= fetches_in;
        end
    end

    // busy from start until the last clock of the last machine cycle
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            busy_q <= 1'b0;
        end else if (start_in && !busy_q) begin
            busy_q <= 1'b1;
        end else if (last_out) begin
            busy_q <= 1'b0;
        end
    end

    assign last_out = busy_q && end_of_mc && (mcyc_q == total_q - 3'h1);
    // one fetch on the first clock of each fetching machine cycle
    assign fetch_out = busy_q && (phase_q == 2'h0) && (mcyc_q < fetches_q);
    assign busy_out = busy_q;
    assign phase_out = phase_q;
    assign mcycle_out = mcyc_q;

endmodule
`default_nettype wire

/* tb/cpu_core_sva.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_regs.svh"
module cpu_core_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic busy_out,
    input wire logic fetch_strobe_out,
    input wire logic [4:0] bank_base_out,
    input wire cpu_core_pkg::psw_t psw_out,
    input wire logic [7:0] acc_out
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [4:0] run_q;
    logic wr_ok;
    logic mapped;
    // a write counts only where the slave answers ready
    assign wr_ok = psel_in && penable_in && pwrite_in && pready_out;
    assign mapped = paddr_in inside {`OFS_CMD, `OFS_STAT, `OFS_PSW, `OFS_ACC, `OFS_B};
    // busy run length, judged when busy falls
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            run_q <= 5'h00;
        end else begin
            run_q <= busy_out ? run_q + 5'h01 : 5'h00;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_bank;
        bank_base_out == {psw_out.bank_select_high, psw_out.bank_select_low, 3'b000};
    endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong");
    property p_parity;
        psw_out.parity_flag == ^acc_out;
    endproperty
    a_parity: assert property (p_parity) else $error("parity wrong");
    property p_fetch_in_busy;
        fetch_strobe_out |-> busy_out;
    endproperty
    a_fetch_in_busy: assert property (p_fetch_in_busy) else $error("fetch while idle");
    property p_fetch_gap;
        fetch_strobe_out |=> !fetch_strobe_out [*3];
    endproperty
    a_fetch_gap: assert property (p_fetch_gap) else $error("fetches too close");
    property p_first_cycle;
        $rose(busy_out) |-> fetch_strobe_out ##1 (busy_out && !fetch_strobe_out) [*3];
    endproperty
    a_first_cycle: assert property (p_first_cycle) else $error("bad first cycle");
    property p_run_len;
        $fell(busy_out) |-> run_q[1:0] == 2'b00 && run_q >= 5'h04 && run_q <= 5'h10;
    endproperty
    a_run_len: assert property (p_run_len) else $error("busy not whole cycles");
    property p_user;
        !(wr_ok && paddr_in == `OFS_PSW) |=> $stable(psw_out[5:3]) && $stable(psw_out[1]);
    endproperty
    a_user: assert property (p_user) else $error("user bits changed");
    property p_acc_cause;
        $changed(acc_out) |-> $past(busy_out) || $past(wr_ok && paddr_in == `OFS_ACC);
    endproperty
    a_acc_cause: assert property (p_acc_cause) else $error("acc changed alone");
    property p_stall;
        psel_in && pwrite_in |-> (pready_out == !busy_out);
    endproperty
    a_stall: assert property (p_stall) else $error("write not stalled");
    property p_unmapped;
        psel_in && penable_in && pready_out && !mapped |-> pslverr_out;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on hole");
    c_long: cover property ($fell(busy_out) && run_q == 5'h10);
    c_stall: cover property (psel_in && pwrite_in && busy_out);
    c_err: cover property (pslverr_out);
endmodule
bind cpu_flags_and_cycle_timing cpu_core_sva #(.ADDR_W(ADDR_W)) u_sva (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .busy_out(busy_out), .fetch_strobe_out(fetch_strobe_out),
    .bank_base_out(bank_base_out), .psw_out(psw_out), .acc_out(acc_out));
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_regs.svh"
module testbench;
    logic mclk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic pready_out, pslverr_out, busy_out, fetch_strobe_out;
    logic [4:0] bank_base_out;
    cpu_core_pkg::psw_t psw_out;
    logic [7:0] acc_out, b_out, m_acc = 0, m_b = 0, m_psw = 0;
    int n_mismatch = 0, tests_run = 0;
    cpu_flags_and_cycle_timing dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .busy_out(busy_out),
        .fetch_strobe_out(fetch_strobe_out), .bank_base_out(bank_base_out),
        .psw_out(psw_out), .acc_out(acc_out), .b_out(b_out));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic end_of_test;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; returns data, error and count of wait edges
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e, output int n);
        @(posedge mclk_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1;
        n = -1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 200);
        if (pready_out !== 1'b1) n_mismatch++;
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask
    // behavioural datapath, integer arithmetic on the carry bits
    task automatic model(input int op, input logic [7:0] o);
        int a, s, c;
        a = m_acc;
        c = m_psw[7];
        case (op)
            1, 2, 3: begin
                if (op == 1) c = 0;
                s = (op == 3) ? a - o - c : a + o + c;
                m_psw[6] = (op == 3) ? a % 16 < o % 16 + c : a % 16 + o % 16 + c > 15;
                m_psw[7] = (op == 3) ? s < 0 : s > 255;
                m_psw[2] = m_psw[7] ^ ((op == 3) ? a % 128 < o % 128 + c
                    : a % 128 + o % 128 + c > 127);
                m_acc = s[7:0];
            end
            4: begin
                s = a * m_b;
                {m_b, m_acc} = s[15:0];
                m_psw[7] = 0;
                m_psw[2] = s > 255;
            end
            5: begin
                m_psw[7] = 0;
                m_psw[2] = m_b == 0;
                if (m_b != 0) {m_acc, m_b} = {8'(a / m_b), 8'(a % m_b)};
            end
            6: begin
                s = a;
                if (s % 16 > 9 || m_psw[6]) s += 6;
                if (s > 255) m_psw[7] = 1;
                s = s % 256;
                if (s / 16 > 9 || m_psw[7]) s += 96;
                if (s > 255) m_psw[7] = 1;
                m_acc = s[7:0];
            end
            7: {m_acc, m_psw[7]} = {m_psw[7], m_acc};
            8: {m_psw[7], m_acc} = {m_acc, m_psw[7]};
            9: m_psw[7] = 0;
            10: m_psw[7] = 1;
            11: m_psw[7] = !c;
            12: m_psw[7] = c & o[0];
            13: m_psw[7] = c & !o[0];
            14: m_psw[7] = c | o[0];
            15: m_psw[7] = c | !o[0];
            16: m_psw[7] = o[0];
            17: m_psw[7] = a < o;
            20: m_acc = m_acc & o;
            21: m_acc = m_acc | o;
            22: m_acc = m_acc ^ o;
            23: m_acc = o;
            default: ;
        endcase
        m_psw[0] = ^m_acc;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic run(input int op, input int nb);
        logic [31:0] r;
        logic e;
        int n, f, w;
        logic [7:0] o;
        o = 8'($urandom);
        apb(1, `OFS_CMD, {8'h00, o, 6'h00, 2'(nb), 3'h0, 5'(op)}, r, e, w);
        n = 0;
        f = 0;
        // sampled on the falling edge so the launch edge has settled
        repeat (22) begin
            @(negedge mclk_in);
            n += (busy_out === 1'b1);
            f += (fetch_strobe_out === 1'b1);
        end
        model(op, o);
        if (nb == 0) nb = 1;
        check(n, 4 * (nb + (op inside {17, 18, 19})));
        check(f, nb);
        check(psw_out, m_psw);
        check(acc_out, m_acc);
        check(b_out, m_b);
        check(bank_base_out, {m_psw[4:3], 3'b000});
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        int w;
        apb(1, a, {24'h0, d}, r, e, w);
        apb(0, a, 32'h0, r, e, w);
        check(r, {24'h0, x});
        check(e, 0);
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        int w;
        logic [7:0] d;
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1;
        void'($urandom(32'hd1db));
        apb(0, `OFS_PSW, 32'h0, r, e, w);
        check(r, 32'h0);
        apb(1, 8'h0c, 32'hff, r, e, w);
        apb(0, 8'h08, 32'h0, r, e, w);
        check(r, 32'h0);
        check(e, 1);
        check(acc_out, 8'h00);
        for (int i = 0; i < 72; i++) begin
            d = $urandom;
            m_acc = d;
            wr_rd(`OFS_ACC, d, d);
            d = $urandom;
            m_b = d;
            wr_rd(`OFS_B, d, d);
            d = $urandom;
            m_psw = {d[7:1], ^m_acc};
            wr_rd(`OFS_PSW, d, m_psw);
            run(i % 32, $urandom_range(3, 0));
        end
        // a write during a three-cycle instruction must wait it out
        apb(1, `OFS_CMD, 32'h0000_0300, r, e, w);
        // third clock of the first machine cycle, still busy
        apb(0, `OFS_STAT, 32'h0, r, e, w);
        check(r, 32'h0000_0021);
        d = $urandom;
        apb(1, `OFS_ACC, {24'h0, d}, r, e, w);
        check(w, 7);
        @(negedge mclk_in);
        check(acc_out, d);
        apb(0, `OFS_CMD, 32'h0, r, e, w);
        check(r, 32'h0000_0300);
        end_of_test();
    end
    // cut a hang short well past the expected run length
    initial begin
        #(40 * 20000);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
